// [rtl/cajx_exec.sv]
// Execute stage for relative jumps and add, add-with-carry, and, bit-clear, xor and move.
// Assumes the fetch side presents one decoded word with fetched operands per valid cycle.
`timescale 1ns/100ps

// How it works
// - Jump reach is -511..+512 words around instruction.
// - Taken jump: pc plus 2 plus twice offset.
// - Untaken jump: continue with next sequential word.
// - Jumps leave all four arithmetic flags unchanged.
// - Conditions: carry, no carry, zero, nonzero, negative, always.
// - Signed ge/lt test negative xor overflow.
// - Carry, zero, negative, interrupt enable at masks 1,2,4,8.
// - Byte mark selects 8-bit operands, else 16-bit.
// - Add stores sum and sets all four flags.
// - Add with carry includes incoming carry flag.
// - Adding carry alone carries only on wrap.
// - And sets n, z, carry not zero, clears overflow.
// - Bit clear stores inverted source and destination, flags kept.
// - Mode bits are never touched by these operations.
// - Invert, shift, rotate come from xor and add forms.
// - Move into program counter acts as a branch.
// - Jump word: 3-bit prefix, 3 condition bits, 10-bit offset.
// - Size bit one means byte, zero means word.
module cajx_exec
  import cajx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        req_valid,
  input  wire cajx_req_t   req,
  input  wire logic        sw_load,
  input  wire logic [15:0] sw_load_data,
  output logic             rsp_valid,
  output cajx_rsp_t        rsp,
  output logic [15:0]      status_word
);

  function automatic logic is_jump(input logic [15:0] w);
    is_jump = (w[JMP_PREFIX_HI:JMP_PREFIX_LO] == JUMP_PREFIX);
  endfunction

  cajx_rsp_t   rsp_d, rsp_q;
  logic        vld_d, vld_q;
  logic [15:0] sw_d, sw_q;

  logic        byte_op;
  logic [3:0]  opc;
  logic [16:0] sum;
  logic [15:0] res;
  logic [15:0] src_m, dst_m;
  logic        res_msb, src_msb, dst_msb, cout, zero;
  logic        cond;
  logic [15:0] ofs_ext;
  cajx_jcond_t jc;

  always_comb begin
    rsp_d   = rsp_q;
    vld_d   = req_valid;
    sw_d    = sw_q;
    opc     = req.instr[OP_HI:OP_LO];
    byte_op = req.instr[SIZE_BIT];
    src_m   = byte_op ? {8'h00, req.src[7:0]} : req.src;
    dst_m   = byte_op ? {8'h00, req.dst[7:0]} : req.dst;
    sum     = {1'b0, src_m} + {1'b0, dst_m}
              + {16'h0000, (opc == OPC_ADD_WITH_CARRY_OP) ? sw_q[SW_CARRY_BIT] : 1'b0};
    res     = 16'h0000;
    jc      = cajx_jcond_t'(req.instr[JMP_COND_HI:JMP_COND_LO]);
    cond    = 1'b0;
    // Sign extension happens before the shift so negative offsets keep their range.
    ofs_ext = {{(DATA_W - JMP_OFS_W){req.instr[JMP_OFS_HI]}}, req.instr[JMP_OFS_HI:0]};
    unique case (jc)
      JC_NOT_EQUAL: cond = ~sw_q[SW_ZERO_BIT];
      JC_EQUAL:     cond = sw_q[SW_ZERO_BIT];
      JC_NO_CARRY:  cond = ~sw_q[SW_CARRY_BIT];
      JC_CARRY:     cond = sw_q[SW_CARRY_BIT];
      JC_NEGATIVE:  cond = sw_q[SW_NEG_BIT];
      JC_SIGNED_GE: cond = (sw_q[SW_NEG_BIT] ^ sw_q[SW_OVF_BIT]) == 1'b0;
      JC_SIGNED_LT: cond = (sw_q[SW_NEG_BIT] ^ sw_q[SW_OVF_BIT]) == 1'b1;
      JC_ALWAYS:    cond = 1'b1;
    endcase
    unique case (opc)
      OPC_ADD, OPC_ADD_WITH_CARRY_OP: res = sum[15:0];
      OPC_AND:           res = src_m & dst_m;
      OPC_BIC:           res = ~src_m & dst_m;
      OPC_XOR:           res = src_m ^ dst_m;
      default:           res = src_m;
    endcase
    if (byte_op) begin
      res = {8'h00, res[7:0]};
    end
    res_msb = byte_op ? res[7] : res[15];
    src_msb = byte_op ? src_m[7] : src_m[15];
    dst_msb = byte_op ? dst_m[7] : dst_m[15];
    cout    = byte_op ? sum[8] : sum[16];
    zero    = (res == 16'h0000);
    if (req_valid) begin
      rsp_d.taken     = 1'b0;
      rsp_d.result    = res;
      rsp_d.result_we = 1'b0;
      rsp_d.pc_next   = req.pc + PC_STEP;
      if (is_jump(req.instr)) begin
        // Flags are deliberately not written on this path.
        if (cond) begin
          rsp_d.taken   = 1'b1;
          rsp_d.pc_next = req.pc + PC_STEP + {ofs_ext[14:0], 1'b0};
        end
      end else begin
        rsp_d.result_we = 1'b1;
        if (req.dst_is_pc) begin
          // A write to the program counter is a branch (pop to pc gives return).
          rsp_d.taken   = 1'b1;
          rsp_d.pc_next = res;
        end
        // Only bits 0..2 and 8 change; mode bits stay put.
        unique case (opc)
          OPC_ADD, OPC_ADD_WITH_CARRY_OP: begin
            sw_d[SW_NEG_BIT]   = res_msb;
            sw_d[SW_ZERO_BIT]  = zero;
            sw_d[SW_CARRY_BIT] = cout;
            sw_d[SW_OVF_BIT]   = (src_msb == dst_msb) && (res_msb != src_msb);
          end
          OPC_AND, OPC_XOR: begin
            sw_d[SW_NEG_BIT]   = res_msb;
            sw_d[SW_ZERO_BIT]  = zero;
            sw_d[SW_CARRY_BIT] = ~zero;
            sw_d[SW_OVF_BIT]   = (opc == OPC_XOR) ? (src_msb & dst_msb) : 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
    if (sw_load) begin
      sw_d = sw_load_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_q <= '0;
      vld_q <= 1'b0;
      sw_q  <= SW_RESET;
    end else begin
      rsp_q <= rsp_d;
      vld_q <= vld_d;
      sw_q  <= sw_d;
    end
  end

  assign rsp         = rsp_q;
  assign rsp_valid   = vld_q;
  assign status_word = sw_q;

endmodule

// [include/cajx_pkg.sv]
// Constants and types shared by the jump and arithmetic execute unit.
// Assumes a 16-bit core with one address space and byte-addressed program words.
package cajx_pkg;

  localparam int DATA_W = 16;

  // Status word bit positions (masks 1, 2, 4, 8 map to bits 0..3).
  localparam int SW_CARRY_BIT = 0;
  localparam int SW_ZERO_BIT  = 1;
  localparam int SW_NEG_BIT   = 2;
  localparam int SW_GIE_BIT   = 3;
  localparam int SW_CORE_HALT_BIT_BIT = 4;
  localparam int SW_OSCILLATOR_HALT_BIT_BIT = 5;
  localparam int SW_OVF_BIT   = 8;
  localparam logic [15:0] SW_RESET = 16'h0000;

  // Jump word layout.
  localparam logic [2:0] JUMP_PREFIX = 3'b001;
  localparam int JMP_PREFIX_HI = 15;
  localparam int JMP_PREFIX_LO = 13;
  localparam int JMP_COND_HI   = 12;
  localparam int JMP_COND_LO   = 10;
  localparam int JMP_OFS_HI    = 9;
  localparam int JMP_OFS_W     = 10;
  localparam logic [15:0] PC_STEP = 16'h0002;

  // Double-operand word layout.
  localparam int OP_HI   = 15;
  localparam int OP_LO   = 12;
  localparam int SIZE_BIT = 6;

  typedef enum logic [2:0] {
    JC_NOT_EQUAL   = 3'b000,
    JC_EQUAL       = 3'b001,
    JC_NO_CARRY    = 3'b010,
    JC_CARRY       = 3'b011,
    JC_NEGATIVE    = 3'b100,
    JC_SIGNED_GE   = 3'b101,
    JC_SIGNED_LT   = 3'b110,
    JC_ALWAYS      = 3'b111
  } cajx_jcond_t;

  // Double-operand opcodes handled here; others pass status unchanged.
  localparam logic [3:0] OPC_MOV  = 4'h4;
  localparam logic [3:0] OPC_ADD  = 4'h5;
  localparam logic [3:0] OPC_ADD_WITH_CARRY_OP = 4'h6;
  localparam logic [3:0] OPC_XOR  = 4'he;
  localparam logic [3:0] OPC_BIC  = 4'hc;
  localparam logic [3:0] OPC_AND  = 4'hf;

  typedef struct packed {
    logic [15:0] instr;
    logic [15:0] pc;
    logic [15:0] src;
    logic [15:0] dst;
    logic        dst_is_pc;
  } cajx_req_t;

  typedef struct packed {
    logic [15:0] result;
    logic        result_we;
    logic [15:0] pc_next;
    logic        taken;
  } cajx_rsp_t;

endpackage

// [bench/cajx_exec_assertions.sv]
// Port checks for the jump and arithmetic execute unit.
// Assumes a bind to cajx_exec; cycles with sw_load are kept out of flag checks.
`timescale 1ns/100ps
module cajx_exec_assertions
  import cajx_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        req_valid,
  input wire cajx_req_t   req,
  input wire logic        sw_load,
  input wire logic [15:0] sw_load_data,
  input wire logic        rsp_valid,
  input wire cajx_rsp_t   rsp,
  input wire logic [15:0] status_word
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic       go;
  logic       jump_always;
  logic [2:0] cnd;
  logic [3:0] opc;
  assign go  = req_valid && !sw_load;
  assign jump_always = go && req.instr[15:13] == JUMP_PREFIX;
  assign cnd = req.instr[12:10];
  assign opc = req.instr[15:12];
  a_jump_target: assert property (jump_always |=> rsp.pc_next == $past(req.pc) + 16'h2 +
    (rsp.taken ? {{5{$past(req.instr[9])}}, $past(req.instr[9:0]), 1'b0} : 16'h0))
    else $error("jump pc");
  a_carry_cond: assert property (
    jump_always && cnd == 3'b011 |=> rsp.taken == $past(status_word[0])) else $error("jump c");
  a_signed_ge: assert property (
    jump_always && cnd == 3'b101 |=> rsp.taken == ($past(status_word[2]) == $past(status_word[8])))
    else $error("jump ge");
  a_jump_flags: assert property (
    jump_always |=> $stable(status_word)) else $error("jump flags");
  a_bic_flags: assert property (
    go && opc == OPC_BIC |=> $stable(status_word)) else $error("bic flags");
  a_mode_bits: assert property (
    go |=> status_word[5:3] == $past(status_word[5:3])) else $error("mode bits");
  a_and_flags: assert property (
    go && opc == OPC_AND |=> !status_word[8] && status_word[0] != status_word[1])
    else $error("and flags");
  a_byte_high: assert property (
    go && req.instr[6] && opc >= OPC_MOV |=> rsp.result[15:8] == 8'h0) else $error("byte");
  cover property (jump_always ##1 rsp.taken);
  cover property (go && opc == OPC_ADD_WITH_CARRY_OP);
  cover property (go && req.dst_is_pc);
  cover property (go && opc == OPC_AND && req.instr[6]);
endmodule

// [bench/cajx_fetch_model.sv]
// Program memory model that serves instruction words by address.
// Assumes the bench fills mem first; unfilled words read as unknown.
`timescale 1ns/100ps
module cajx_fetch_model (
  input  wire logic [15:0] addr,
  output logic [15:0]      word
);
  logic [15:0] mem [0:255];
  // Words sit on even addresses, so bit 0 never selects a word.
  assign word = mem[addr[8:1]];
endmodule

// [bench/tb_cpu_alu_and_jump_execute.sv]
// Self-checking bench for the jump and arithmetic execute unit.
// Assumes the package, fetch model and checker are compiled first.
`timescale 1ns/100ps
module tb_cpu_alu_and_jump_execute;
  import cajx_pkg::*;
  logic        core_clk = 0, rst = 1, req_valid = 0, sw_load = 0, rsp_valid, t;
  logic [15:0] sw_load_data = 0, word, status_word, s;
  cajx_req_t   req = '0;
  cajx_rsp_t   rsp;
  int          fails = 0, n_checks = 0;
  always #4 core_clk = ~core_clk;
  cajx_exec cajx_exec_inst (.core_clk(core_clk), .rst(rst), .req_valid(req_valid),
    .req(req), .sw_load(sw_load), .sw_load_data(sw_load_data), .rsp_valid(rsp_valid),
    .rsp(rsp), .status_word(status_word));
  cajx_fetch_model cajx_fetch_model_inst (.addr(req.pc), .word(word));
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Each step preloads the status word so expectations do not chain between steps.
  task automatic run(input logic [15:0] i, pc, a, d, r, pcn, si, so, input logic pcd = 0);
    @(negedge core_clk) sw_load = 1;
    sw_load_data = si;
    cajx_fetch_model_inst.mem[pc[8:1]] = i;
    req = '{16'h0, pc, a, d, pcd};
    @(negedge core_clk) sw_load = 0;
    req.instr = word;
    req_valid = 1;
    @(negedge core_clk) req_valid = 0;
    chk({15'h0, rsp_valid}, 16'h1);
    if (i[15:13] != JUMP_PREFIX) chk(rsp.result, r);
    chk(rsp.pc_next, pcn);
    chk({15'h0, rsp.taken}, {15'h0, pcn != pc + PC_STEP});
    chk({15'h0, rsp.result_we}, {15'h0, i[15:13] != JUMP_PREFIX});
    chk(status_word, so);
  endtask
  task automatic alu(input logic [15:0] i, a, d, r, si, so);
    run(i, 16'h100, a, d, r, 16'h102, si, so);
  endtask
  initial begin
    repeat (10) @(negedge core_clk);
    rst = 0;
    chk(status_word, SW_RESET);
    alu(16'h5000, 16'h7fff, 16'h1, 16'h8000, 16'h0, 16'h104);
    alu(16'h5040, 16'h12ff, 16'h3401, 16'h0, 16'h0, 16'h3);
    alu(16'h6000, 16'h0, 16'hffff, 16'h0, 16'h1, 16'h3);
    alu(16'h6040, 16'h0, 16'hfe, 16'hff, 16'h1, 16'h4);
    alu(16'h6000, 16'h8001, 16'h8001, 16'h3, 16'h39, 16'h139);
    alu(16'h5000, 16'h4000, 16'h4000, 16'h8000, 16'h38, 16'h13c);
    alu(16'hf000, 16'hf0f, 16'hf0, 16'h0, 16'h138, 16'h3a);
    alu(16'hc000, 16'hff, 16'h1234, 16'h1200, 16'h13d, 16'h13d);
    alu(16'he000, 16'hffff, 16'hff, 16'hff00, 16'h38, 16'h3d);
    run(16'h4000, 16'h100, 16'h200, 16'h0, 16'h200, 16'h200, 16'h0, 16'h0, 1);
    $display("test alu done");
    for (int k = 0; k < 16; k++)
      for (int c = 0; c < 8; c++) begin
        s = {7'h0, k[3], 5'h0, k[2:0]};
        t = c == 0 ? !k[1] : c == 1 ? k[1] : c == 2 ? !k[0] : c == 3 ? k[0] :
            c == 4 ? k[2] : c == 5 ? k[2] == k[3] : c == 6 ? k[2] != k[3] : 1;
        run({JUMP_PREFIX, c[2:0], c[0] ? 10'h1ff : 10'h200}, 16'h1000, 16'h0,
            16'h0, 16'h0, t ? (c[0] ? 16'h1400 : 16'hc02) : 16'h1002, s, s);
      end
    $display("test jump done");
    end_of_test();
  end
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule
bind cajx_exec cajx_exec_assertions cajx_exec_assertions_inst (.core_clk(core_clk),
  .rst(rst), .req_valid(req_valid), .req(req), .sw_load(sw_load), .sw_load_data(sw_load_data),
  .rsp_valid(rsp_valid), .rsp(rsp), .status_word(status_word));
